// file: dv/ccbd_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccbd_ctl_model (
    input wire logic clk,
    output logic ctl_serial_clk,
    output logic ctl_serial_data,
    output logic ctl_phase_sel
);
    initial begin
        ctl_serial_clk = 1'b0;
        ctl_serial_data = 1'b0;
        ctl_phase_sel = 1'b0;
    end
    // serial clock stands low between frames; n < 8 leaves a partial byte
    task automatic send(input logic ph, input logic [7:0] b, input int n);
        @(negedge clk);
        ctl_phase_sel = ph;
        for (int i = 0; i < n; i++) begin
            ctl_serial_data = b[i];
            repeat (4) @(negedge clk);
            ctl_serial_clk = 1'b1;
            repeat (4) @(negedge clk);
            ctl_serial_clk = 1'b0;
        end
        // stale level inverted so a late sample cannot pass by luck
        ctl_serial_data = ~b[n-1];
    endtask
endmodule
`default_nettype wire

// file: dv/ccbd_props.sv
`timescale 1ns/10ps
`default_nettype none
module ccbd_props
    import ccbd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ctl_serial_clk,
    input wire logic ctl_serial_data,
    input wire logic ctl_phase_sel,
    input wire logic [1:0] clk_ratio,
    input wire logic [2:0] fmt_sel,
    input wire logic offset_removal_en,
    input wire logic [5:0] atten_left,
    input wire logic [5:0] atten_right,
    input wire logic atten_silent,
    input wire logic [1:0] emph_sel,
    input wire logic playback_silence,
    input wire logic adc_power_on,
    input wire logic dac_power_on
);
    wire logic [5:0] cfg_w = {clk_ratio, fmt_sel, offset_removal_en};
    wire logic [10:0] snd_w = {atten_left, emph_sel, playback_silence, adc_power_on, dac_power_on};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chan_match_a: assert property (atten_left == atten_right)
        else $error("left and right volume differ");
    silent_flag_a: assert property (
        atten_silent == (atten_left >= CCBD_ATTEN_SILENT))
        else $error("silent flag does not follow volume code");
    // sync plus commit latency lands inside the serial clock high time
    commit_time_a: assert property (
        $changed({cfg_w, snd_w}) |->
        $past(ctl_serial_clk, 4) || $past(ctl_serial_clk, 5) || $past(ctl_serial_clk, 6))
        else $error("register changed away from a byte end");
    commit_phase_a: assert property (
        $changed({cfg_w, snd_w}) |-> $past(ctl_phase_sel, 5))
        else $error("register changed from an address byte");
    group_excl_a: assert property (!($changed(cfg_w) && $changed(snd_w)))
        else $error("both groups changed at once");
    reg_excl_a: assert property (
        $onehot0({$changed(atten_left), $changed({emph_sel, playback_silence}),
        $changed({adc_power_on, dac_power_on})}))
        else $error("one byte changed two registers");
    addr_quiet_a: assert property (
        !ctl_phase_sel [*8] |=> $stable({cfg_w, snd_w}))
        else $error("register changed during address phase");
    reset_zero_a: assert property (disable iff (1'b0) $fell(rst) |-> {cfg_w, snd_w} == '0)
        else $error("registers not cleared by reset");
endmodule
bind ccbd_top ccbd_props u_props (.clk(clk), .rst(rst), .ctl_serial_clk(ctl_serial_clk),
    .ctl_serial_data(ctl_serial_data), .ctl_phase_sel(ctl_phase_sel), .clk_ratio(clk_ratio),
    .fmt_sel(fmt_sel), .offset_removal_en(offset_removal_en), .atten_left(atten_left),
    .atten_right(atten_right), .atten_silent(atten_silent), .emph_sel(emph_sel),
    .playback_silence(playback_silence), .adc_power_on(adc_power_on), .dac_power_on(dac_power_on));
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ccbd_pkg::*;
    localparam logic [5:0] DEV = 6'h2A; // arbitrary address
    logic clk = 1'b0;
    logic rst = 1'b1;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] exp_b;
    logic [5:0] vols [4] = '{6'h01, 6'h38, 6'h39, 6'h3F};
    wire logic s_clk, s_dat, s_ph, offs, sil, mute, adc, dac;
    wire logic [1:0] ratio, emph;
    wire logic [2:0] fmt;
    wire logic [5:0] al, ar;
    ccbd_ctl_model m (.clk(clk), .ctl_serial_clk(s_clk), .ctl_serial_data(s_dat),
        .ctl_phase_sel(s_ph));
    ccbd_top #(.DEV_ADDR(DEV)) dut (.clk(clk), .rst(rst), .ctl_serial_clk(s_clk),
        .ctl_serial_data(s_dat), .ctl_phase_sel(s_ph), .clk_ratio(ratio), .fmt_sel(fmt),
        .offset_removal_en(offs), .atten_left(al), .atten_right(ar), .atten_silent(sil),
        .emph_sel(emph), .playback_silence(mute), .adc_power_on(adc), .dac_power_on(dac));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic put(input logic [7:0] b);
        m.send(1'b1, b, 8);
        repeat (8) @(negedge clk);
    endtask
    task automatic addr(input logic [1:0] g);
        m.send(1'b0, {DEV, g}, 8);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        addr(CCBD_GRP_STATUS);
        for (int i = 0; i < 8; i++) begin
            exp_b = {CCBD_SEL_CFG, 2'(i % 3), 3'(7 - i), 1'(i)};
            put(exp_b);
            chk("cfg", exp_b, {2'b00, ratio, fmt, offs});
        end
        addr(CCBD_GRP_DATA);
        chk("cfg hold", exp_b, {2'b00, ratio, fmt, offs});
        foreach (vols[k]) begin
            put({CCBD_SEL_VOL, vols[k]});
            chk("atten_left", {2'b00, vols[k]}, {2'b00, al});
            chk("atten_right", {2'b00, vols[k]}, {2'b00, ar});
            chk("silent", {7'h00, vols[k] >= CCBD_ATTEN_SILENT}, {7'h00, sil});
        end
        for (int i = 0; i < 4; i++) begin
            put({CCBD_SEL_EMPH, 1'b0, 2'(i), 1'(i), 2'b00});
            chk("emph mute", {5'h00, 2'(i), 1'(i)}, {5'h00, emph, mute});
            put({CCBD_SEL_PWR, 4'h0, 2'(i)});
            chk("power", {6'h00, 2'(i)}, {6'h00, adc, dac});
            chk("atten keep", 8'h3F, {2'b00, al});
        end
        put(8'h40);
        chk("unused sel", 8'h1F, {3'h0, emph, mute, adc, dac});
        chk("unused atten", 8'h3F, {2'b00, al});
        // a foreign address deselects, so the volume byte after it must not land
        m.send(1'b0, {~DEV, CCBD_GRP_DATA}, 8);
        put({CCBD_SEL_VOL, 6'h05});
        chk("foreign addr", 8'h3F, {2'b00, al});
        addr(2'h1);
        put({CCBD_SEL_VOL, 6'h05});
        chk("unused group", 8'h3F, {2'b00, al});
        addr(CCBD_GRP_STATUS);
        put(8'hC5);
        chk("cfg other sel", exp_b, {2'b00, ratio, fmt, offs});
        m.send(1'b1, 8'h00, 5);
        addr(CCBD_GRP_DATA);
        chk("partial byte", 8'h3F, {2'b00, al});
        // a kept partial byte would misalign the address and this byte
        put({CCBD_SEL_VOL, 6'h15});
        chk("realigned", 8'h15, {2'b00, al});
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire

// file: verilog/ccbd_pkg.sv
`default_nettype none
package ccbd_pkg;
    // group select values carried in address bits 1:0
    localparam logic [1:0] CCBD_GRP_DATA = 2'h0;
    localparam logic [1:0] CCBD_GRP_STATUS = 2'h2;
    // register select values carried in data bits 7:6
    localparam logic [1:0] CCBD_SEL_VOL = 2'h0;
    localparam logic [1:0] CCBD_SEL_UNUSED = 2'h1;
    localparam logic [1:0] CCBD_SEL_EMPH = 2'h2;
    localparam logic [1:0] CCBD_SEL_PWR = 2'h3;
    localparam logic [1:0] CCBD_SEL_CFG = 2'h0;
    // field positions
    localparam int CCBD_SEL_MSB = 7;
    localparam int CCBD_SEL_LSB = 6;
    localparam int CCBD_RATIO_LSB = 4;
    localparam int CCBD_FMT_LSB = 1;
    localparam int CCBD_OFFS_BIT = 0;
    localparam int CCBD_EMPH_LSB = 3;
    localparam int CCBD_MUTE_BIT = 2;
    localparam int CCBD_PWR_LSB = 0;
    localparam int CCBD_BYTE_BITS = 8;
    // clock ratio codes
    localparam logic [1:0] CCBD_RATIO_512 = 2'h0;
    localparam logic [1:0] CCBD_RATIO_384 = 2'h1;
    localparam logic [1:0] CCBD_RATIO_256 = 2'h2;
    // de-emphasis codes
    localparam logic [1:0] CCBD_EMPH_NONE = 2'h0;
    localparam logic [1:0] CCBD_EMPH_32K = 2'h1;
    localparam logic [1:0] CCBD_EMPH_44K1 = 2'h2;
    localparam logic [1:0] CCBD_EMPH_48K = 2'h3;
    // volume codes: first silent code
    localparam logic [5:0] CCBD_ATTEN_SILENT = 6'h39;
    // reset values of the control registers (the real part has none)
    localparam logic [5:0] CCBD_RST_VALUE = 6'h00;

    typedef struct packed {
        logic [1:0] clk_ratio;
        logic [2:0] fmt_sel;
        logic offset_removal_en;
    } ccbd_cfg_t;

    typedef struct packed {
        logic [5:0] atten;
        logic [1:0] emph_sel;
        logic playback_silence;
        logic adc_power_on;
        logic dac_power_on;
    } ccbd_snd_t;

    typedef struct packed {
        logic valid;
        logic addr_phase;
        logic [7:0] data;
    } ccbd_byte_t;
endpackage
`default_nettype wire

// file: verilog/ccbd_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module ccbd_shifter
    import ccbd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ctl_serial_clk,
    input wire logic ctl_serial_data,
    input wire logic ctl_phase_sel,
    output var ccbd_byte_t byte_out
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [2:0] s1_q, s2_q;
    logic clk_prev_q;
    logic phase_q;
    always_ff @(posedge clk) begin
        s1_q <= {ctl_serial_clk, ctl_serial_data, ctl_phase_sel};
        s2_q <= s1_q;
        clk_prev_q <= s2_q[2];
    end
    wire sclk_rise = s2_q[2] && !clk_prev_q;
    wire phase_chg = s2_q[0] != phase_q;

    // ----------------------------------------
    // shift and count
    // ----------------------------------------
    logic [7:0] shreg_q;
    logic [2:0] cnt_q;
    wire [7:0] shreg_d = {s2_q[1], shreg_q[7:1]};
    wire last_bit = cnt_q == 3'(CCBD_BYTE_BITS - 1);
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= 1'b0;
            cnt_q <= 3'h0;
            shreg_q <= 8'h00;
            byte_out <= '0;
        end else begin
            phase_q <= s2_q[0];
            byte_out.valid <= 1'b0;
            // a change of phase line aborts any partial byte
            if (phase_chg) begin
                cnt_q <= 3'h0;
            end else if (sclk_rise) begin
                shreg_q <= shreg_d;
                cnt_q <= cnt_q + 3'h1;
                if (last_bit) begin
                    byte_out.valid <= 1'b1;
                    byte_out.data <= shreg_d;
                    byte_out.addr_phase <= !phase_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/ccbd_top.sv
// Operation
// - data bits 7:6 pick the target register
// - data bits 5:0 load into that register
// - config byte: ratio 5:4, format 3:1, filter 0
// - ratio codes 512, 384, 256, 11 unused
// - format code picks one of eight layouts
// - filter enable bit drives removal filter
// - data group selector 00 loads volume
// - volume code maps to attenuation, top silent
// - one volume value for both channels
// - selector 10: emphasis 4:3, mute bit 2
// - emphasis codes none, 32, 44.1, 48 kHz
// - mute flag silences playback path
// - selector 11 sets ADC/DAC power bits
// - bytes arrive least significant bit first
// - commit only after the eighth bit
// - group choice holds until next address
`timescale 1ns/10ps
`default_nettype none
module ccbd_top
    import ccbd_pkg::*;
#(
    parameter logic [5:0] DEV_ADDR = 6'h2A // arbitrary device address
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ctl_serial_clk,
    input wire logic ctl_serial_data,
    input wire logic ctl_phase_sel,
    output logic [1:0] clk_ratio,
    output logic [2:0] fmt_sel,
    output logic offset_removal_en,
    output logic [5:0] atten_left,
    output logic [5:0] atten_right,
    output logic atten_silent,
    output logic [1:0] emph_sel,
    output logic playback_silence,
    output logic adc_power_on,
    output logic dac_power_on
);
    ccbd_byte_t rx;

    ccbd_shifter u_shift (
        .clk(clk),
        .rst(rst),
        .ctl_serial_clk(ctl_serial_clk),
        .ctl_serial_data(ctl_serial_data),
        .ctl_phase_sel(ctl_phase_sel),
        .byte_out(rx)
    );

    // ----------------------------------------
    // address phase: selection and group
    // ----------------------------------------
    logic sel_q;
    logic [1:0] grp_q;
    wire addr_byte = rx.valid && rx.addr_phase;
    wire data_byte = rx.valid && !rx.addr_phase && sel_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q <= 1'b0;
            grp_q <= CCBD_GRP_DATA;
        end else if (addr_byte) begin
            sel_q <= rx.data[7:2] == DEV_ADDR;
            grp_q <= rx.data[1:0];
        end
    end

    // ----------------------------------------
    // data decode
    // ----------------------------------------
    wire [1:0] reg_sel = rx.data[CCBD_SEL_MSB:CCBD_SEL_LSB];
    wire [5:0] val = rx.data[5:0];
    // group and selector must both match; unused groups match nothing
    function automatic logic reg_hit(input logic [1:0] grp, input logic [1:0] want_grp,
            input logic [1:0] sel, input logic [1:0] want_sel);
        return (grp == want_grp) && (sel == want_sel);
    endfunction
    wire wr_cfg = data_byte && reg_hit(grp_q, CCBD_GRP_STATUS, reg_sel, CCBD_SEL_CFG);
    wire wr_vol = data_byte && reg_hit(grp_q, CCBD_GRP_DATA, reg_sel, CCBD_SEL_VOL);
    wire wr_emph = data_byte && reg_hit(grp_q, CCBD_GRP_DATA, reg_sel, CCBD_SEL_EMPH);
    wire wr_pwr = data_byte && reg_hit(grp_q, CCBD_GRP_DATA, reg_sel, CCBD_SEL_PWR);
    // selector 01 matches no strobe, so it changes nothing

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    ccbd_cfg_t cfg_q;
    ccbd_snd_t snd_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
            snd_q <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_q.clk_ratio <= val[CCBD_RATIO_LSB +: 2];
                cfg_q.fmt_sel <= val[CCBD_FMT_LSB +: 3];
                cfg_q.offset_removal_en <= val[CCBD_OFFS_BIT];
            end
            if (wr_vol) begin
                snd_q.atten <= val;
            end
            if (wr_emph) begin
                snd_q.emph_sel <= val[CCBD_EMPH_LSB +: 2];
                snd_q.playback_silence <= val[CCBD_MUTE_BIT];
            end
            if (wr_pwr) begin
                snd_q.adc_power_on <= val[CCBD_PWR_LSB + 1];
                snd_q.dac_power_on <= val[CCBD_PWR_LSB];
            end
        end
    end

    // ----------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------
    always_comb begin
        clk_ratio = cfg_q.clk_ratio;
        fmt_sel = cfg_q.fmt_sel;
        offset_removal_en = cfg_q.offset_removal_en;
        emph_sel = snd_q.emph_sel;
        playback_silence = snd_q.playback_silence;
        adc_power_on = snd_q.adc_power_on;
        dac_power_on = snd_q.dac_power_on;
        atten_left = snd_q.atten;
        atten_right = snd_q.atten;
    end
    logic silent_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            silent_q <= 1'b0;
        end else if (wr_vol) begin
            silent_q <= val >= CCBD_ATTEN_SILENT;
        end
    end
    assign atten_silent = silent_q;
endmodule
`default_nettype wire
